// ---- core/bfp_pkg.sv ----
// Shared constants and types for the battery fault protection state machine
package bfp_pkg;

  // Clock and derived cycle scale
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // Filter and check times in microseconds; all but the 8 s figure are plain defaults
  localparam int unsigned T_OV_US = 1_000_000;
  localparam int unsigned T_UV_US = 1_000_000;
  localparam int unsigned T_OCD_US = 10_000;
  localparam int unsigned T_SCD_US = 250;
  localparam int unsigned T_SCC_US = 250;
  localparam int unsigned T_THERM_CHECK_US = 100_000;
  localparam int unsigned T_OPEN_CHECK_US = 250_000;
  localparam int unsigned T_UV_SHUT_US = 8_000_000;

  // Cycle counts; each is a whole number of 50 ns periods
  localparam int unsigned OV_CYC = T_OV_US * CYC_PER_US;
  localparam int unsigned UV_CYC = T_UV_US * CYC_PER_US;
  localparam int unsigned OCD_CYC = T_OCD_US * CYC_PER_US;
  localparam int unsigned SCD_CYC = T_SCD_US * CYC_PER_US;
  localparam int unsigned SCC_CYC = T_SCC_US * CYC_PER_US;
  localparam int unsigned THERM_CYC = T_THERM_CHECK_US * CYC_PER_US;
  localparam int unsigned OPEN_CYC = T_OPEN_CHECK_US * CYC_PER_US;
  localparam int unsigned UV_SHUT_CYC = T_UV_SHUT_US * CYC_PER_US;

  // Filter counter width and the two-tick window of the periodic checks
  localparam int unsigned CNT_W = 28;
  localparam logic [CNT_W-1:0] CHECK_TICKS = 28'h000_0002;
  localparam logic [CNT_W-1:0] EVERY_CYCLE = 28'h000_0001;

  // APB register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;

  // Configuration field positions and reset value
  localparam int unsigned CFG_W = 5;
  localparam int unsigned CFG_OV_INHIBIT = 0;
  localparam int unsigned CFG_UV_UNLOAD = 1;
  localparam int unsigned CFG_TEMP_UNLOAD = 2;
  localparam int unsigned CFG_CUR_CHARGER = 3;
  localparam int unsigned CFG_UV_SHUT_EN = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

  // Status layout: state code in the low bits, then the four flags
  localparam int unsigned ST_W = 3;
  localparam int unsigned STAT_LOCKOUT = 3;
  localparam int unsigned STAT_CHARGER = 4;
  localparam int unsigned STAT_UV = 5;
  localparam int unsigned STAT_OV = 6;

  // Interrupt bits: entry to each protection state, then recovery to normal
  localparam int unsigned IRQ_W = 7;
  localparam int unsigned IRQ_RECOVER = 6;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 7'h00;

  // Protection states in ascending priority
  typedef enum logic [ST_W-1:0] {
    ST_NORMAL, ST_OV, ST_UV, ST_OT, ST_CUR, ST_SCC, ST_SHUT
  } bfp_state_type;

  // Reason for a shutdown, which picks its recovery condition
  typedef enum logic [1:0] {
    CAUSE_NONE, CAUSE_TSHORT, CAUSE_OPEN, CAUSE_UV
  } bfp_cause_type;

endpackage

// ---- core/bfp_filter.sv ----
// Restartable fault filter: flags a condition that held for a number of ticks
`timescale 1ns/1ps
`default_nettype none
module bfp_filter import bfp_pkg::*; #(
  parameter int unsigned WIDTH = CNT_W
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cond,
  input wire logic tick,
  input wire logic [WIDTH-1:0] limit,
  output logic hit
);

  logic [WIDTH-1:0] count;

  // Any gap in the condition throws away the time already counted
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (!cond) begin
      count <= '0;
    end else if (tick && count != limit) begin
      count <= count + 1'b1;
    end
  end

  assign hit = cond && (count == limit);

endmodule
`default_nettype wire

// ---- core/bfp_fsm.sv ----
// Fault supervision state machine with APB registers and interrupt
//
// Behaviour
// - Lockout flag high while supply below reset threshold
// - Charger flag high while charger is attached
// - Undervoltage flag high once undervoltage detected
// - Overvoltage flag high once overvoltage detected
// - Overvoltage: charge off, discharge on, optional inhibit
// - Undervoltage: both off, charger re-enables charge
// - Undervoltage recovery may also require load removal
// - Overtemperature: both off, recover per config
// - Discharge current faults: recover on unload/charger
// - Charge short holds until charger removed
// - Thermistor short: shutdown, charger plus clear recovers
// - Open cell: shutdown, charger plus clean period
// - Optional 8 s undervoltage timer enters shutdown
// - Thermistor recoveries complete within one check period
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bfp_fsm import bfp_pkg::*; #(
  parameter int unsigned OV_CYCLES = OV_CYC,
  parameter int unsigned UV_CYCLES = UV_CYC,
  parameter int unsigned OCD_CYCLES = OCD_CYC,
  parameter int unsigned SCD_CYCLES = SCD_CYC,
  parameter int unsigned SCC_CYCLES = SCC_CYC,
  parameter int unsigned THERM_CYCLES = THERM_CYC,
  parameter int unsigned OPEN_CYCLES = OPEN_CYC,
  parameter int unsigned UV_SHUT_CYCLES = UV_SHUT_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator results, all asynchronous to mclk
  input wire logic supplyLow,
  input wire logic chargerPresent,
  input wire logic loadPresent,
  input wire logic cellOver,
  input wire logic cellOverClear,
  input wire logic cellUnder,
  input wire logic cellUnderClear,
  input wire logic tempHot,
  input wire logic tempHotClear,
  input wire logic dischargeOvercurrent,
  input wire logic dischargeShort,
  input wire logic chargeShort,
  input wire logic thermShort,
  input wire logic thermShortClear,
  input wire logic openCell,
  // Power switch gates, open-drain thermistor pin, low-power flag and interrupt
  output logic chargeSwitchDrive,
  output logic dischargeSwitchDrive,
  output logic thermistorPinOut,
  output logic thermistorPinOe,
  output logic lowPowerMode,
  output logic irq
);

  localparam int unsigned NIN = 15;

  logic [NIN-1:0] syncA;
  logic [NIN-1:0] syncB;
  logic lockS, chgS, loadS, ovS, ovClrS, uvS, uvClrS, hotS, hotClrS;
  logic ocdS, scdS, sccS, tshS, tshClrS, openS;
  logic ovHit, uvHit, otHit, ocdHit, scdHit, sccHit, tshHit, openHit;
  logic openClrHit, uvShutHit;
  logic [CNT_W-1:0] thermCnt;
  logic [CNT_W-1:0] openCnt;
  logic thermTick, openTick;
  bfp_state_type state, prevState, faultTarget, next_state;
  bfp_cause_type cause, faultCause, next_cause;
  logic recoverOk;
  logic [CFG_W-1:0] cfgReg;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic [IRQ_W-1:0] irqEvent;
  logic [7:0] stateOneHot;
  logic next_chg, next_dsg;

  // Two-flop synchronisers; only syncB is read by logic
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {supplyLow, chargerPresent, loadPresent, cellOver, cellOverClear,
                cellUnder, cellUnderClear, tempHot, tempHotClear,
                dischargeOvercurrent, dischargeShort, chargeShort,
                thermShort, thermShortClear, openCell};
      syncB <= syncA;
    end
  end

  assign {lockS, chgS, loadS, ovS, ovClrS, uvS, uvClrS, hotS, hotClrS,
          ocdS, scdS, sccS, tshS, tshClrS, openS} = syncB;

  // Periodic check ticks for the thermistor and the open-cell scan
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      thermCnt <= '0;
      openCnt <= '0;
    end else begin
      thermCnt <= thermTick ? '0 : thermCnt + 1'b1;
      openCnt <= openTick ? '0 : openCnt + 1'b1;
    end
  end

  assign thermTick = (thermCnt == CNT_W'(THERM_CYCLES - 1));
  assign openTick = (openCnt == CNT_W'(OPEN_CYCLES - 1));

  // Fault filters; periodic checks need two ticks, so 1 to 2 periods elapse
  bfp_filter uOv (.mclk(mclk), .reset(reset), .cond(ovS), .tick(1'b1),
    .limit(CNT_W'(OV_CYCLES)), .hit(ovHit));
  bfp_filter uUv (.mclk(mclk), .reset(reset), .cond(uvS), .tick(1'b1),
    .limit(CNT_W'(UV_CYCLES)), .hit(uvHit));
  bfp_filter uOt (.mclk(mclk), .reset(reset), .cond(hotS), .tick(thermTick),
    .limit(CHECK_TICKS), .hit(otHit));
  bfp_filter uOcd (.mclk(mclk), .reset(reset), .cond(ocdS), .tick(1'b1),
    .limit(CNT_W'(OCD_CYCLES)), .hit(ocdHit));
  bfp_filter uScd (.mclk(mclk), .reset(reset), .cond(scdS), .tick(1'b1),
    .limit(CNT_W'(SCD_CYCLES)), .hit(scdHit));
  bfp_filter uScc (.mclk(mclk), .reset(reset), .cond(sccS), .tick(1'b1),
    .limit(CNT_W'(SCC_CYCLES)), .hit(sccHit));
  bfp_filter uTsh (.mclk(mclk), .reset(reset), .cond(tshS), .tick(thermTick),
    .limit(CHECK_TICKS), .hit(tshHit));
  bfp_filter uOpen (.mclk(mclk), .reset(reset), .cond(openS), .tick(openTick),
    .limit(CHECK_TICKS), .hit(openHit));
  bfp_filter uOpenClr (.mclk(mclk), .reset(reset), .cond(!openS), .tick(openTick),
    .limit(CHECK_TICKS), .hit(openClrHit));
  bfp_filter uUvShut (.mclk(mclk), .reset(reset),
    .cond(state == ST_UV && cfgReg[CFG_UV_SHUT_EN] && !uvClrS), .tick(1'b1),
    .limit(CNT_W'(UV_SHUT_CYCLES)), .hit(uvShutHit));

  // Highest-priority filtered fault; shutdown causes outrank the rest
  always_comb begin
    faultTarget = ST_NORMAL;
    faultCause = CAUSE_NONE;
    if (tshHit) begin
      faultTarget = ST_SHUT;
      faultCause = CAUSE_TSHORT;
    end else if (openHit) begin
      faultTarget = ST_SHUT;
      faultCause = CAUSE_OPEN;
    end else if (uvShutHit) begin
      faultTarget = ST_SHUT;
      faultCause = CAUSE_UV;
    end else if (sccHit) begin
      faultTarget = ST_SCC;
    end else if (ocdHit || scdHit) begin
      faultTarget = ST_CUR;
    end else if (otHit) begin
      faultTarget = ST_OT;
    end else if (uvHit) begin
      faultTarget = ST_UV;
    end else if (ovHit) begin
      faultTarget = ST_OV;
    end
  end

  // Recovery condition of the present state
  always_comb begin
    unique case (state)
      ST_NORMAL: recoverOk = 1'b0;
      ST_OV: recoverOk = ovClrS;
      ST_UV: recoverOk = uvClrS && (!cfgReg[CFG_UV_UNLOAD] || !loadS);
      ST_OT: recoverOk = thermTick && hotClrS
                         && (!cfgReg[CFG_TEMP_UNLOAD] || !loadS);
      ST_CUR: recoverOk = !loadS && (!cfgReg[CFG_CUR_CHARGER] || chgS);
      ST_SCC: recoverOk = !chgS;
      ST_SHUT: begin
        unique case (cause)
          CAUSE_TSHORT: recoverOk = chgS && tshClrS && thermTick;
          CAUSE_OPEN: recoverOk = chgS && openClrHit;
          default: recoverOk = chgS;
        endcase
      end
      default: recoverOk = 1'b1;
    endcase
  end

  // A higher fault preempts; otherwise recover to normal when allowed
  always_comb begin
    next_state = state;
    next_cause = cause;
    if (faultTarget > state) begin
      next_state = faultTarget;
      next_cause = faultCause;
    end else if (recoverOk) begin
      next_state = ST_NORMAL;
      next_cause = CAUSE_NONE;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= ST_NORMAL;
      prevState <= ST_NORMAL;
      cause <= CAUSE_NONE;
    end else begin
      state <= next_state;
      prevState <= state;
      cause <= next_cause;
    end
  end

  // Gate drive; lockout forces both switches off whatever the state
  assign next_chg = !lockS && (state == ST_NORMAL || (state == ST_UV && chgS));
  assign next_dsg = !lockS && (state == ST_NORMAL || state == ST_OV);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      chargeSwitchDrive <= 1'b0;
      dischargeSwitchDrive <= 1'b0;
      thermistorPinOe <= 1'b0;
      lowPowerMode <= 1'b0;
    end else begin
      chargeSwitchDrive <= next_chg;
      dischargeSwitchDrive <= next_dsg;
      thermistorPinOe <= state == ST_OV && cfgReg[CFG_OV_INHIBIT];
      lowPowerMode <= state == ST_SHUT;
    end
  end

  // The pin is only ever pulled low, never driven high
  assign thermistorPinOut = 1'b0;

  // State entries raise events; bit 6 marks a return to normal
  assign stateOneHot = 8'h01 << state;
  assign irqEvent = (state != prevState)
      ? {state == ST_NORMAL, stateOneHot[6:1]} : IRQ_RESET;

  // APB decode; zero wait states, unmapped addresses answer with an error
  logic hitCfg, hitStat, hitIrq, hitMask, hitAny, wrEn, setup;
  logic [31:0] readMux;
  assign hitCfg = paddr == REG_CONFIG;
  assign hitStat = paddr == REG_STATUS;
  assign hitIrq = paddr == REG_IRQ_STATUS;
  assign hitMask = paddr == REG_IRQ_MASK;
  assign hitAny = hitCfg || hitStat || hitIrq || hitMask;
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hitAny;
  assign readMux = hitCfg ? 32'(cfgReg)
      : hitStat ? 32'({state == ST_OV,
                       state == ST_UV || (state == ST_SHUT && cause == CAUSE_UV),
                       chgS, lockS, state})
      : hitIrq ? 32'(irqStatus)
      : hitMask ? 32'(irqMask) : 32'h0000_0000;

  // Read data captured in the setup cycle so it is steady in access
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= readMux;
    end
  end

  // Config and mask writes; status clears by writing ones, a new event wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfgReg <= CFG_RESET;
      irqMask <= IRQ_RESET;
      irqStatus <= IRQ_RESET;
      irq <= 1'b0;
    end else begin
      if (wrEn && hitCfg) cfgReg <= pwdata[CFG_W-1:0];
      if (wrEn && hitMask) irqMask <= pwdata[IRQ_W-1:0];
      irqStatus <= (irqStatus & ~((wrEn && hitIrq) ? pwdata[IRQ_W-1:0] : IRQ_RESET))
                   | irqEvent;
      irq <= |(irqStatus & irqMask);
    end
  end

  // Checks on the fault behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_lockout_switches: assert property (lockS |=> !chargeSwitchDrive && !dischargeSwitchDrive)
    else $error("Switch on during supply lockout");
  a_ov_entry_filtered: assert property ($rose(state == ST_OV) |-> $past(ovHit))
    else $error("Overvoltage state entered without filtered fault");
  a_ov_drive_pattern: assert property (state == ST_OV && !lockS
      |=> !chargeSwitchDrive && dischargeSwitchDrive)
    else $error("Wrong gate drive in overvoltage");
  a_ov_inhibit_pin: assert property (state == ST_OV && cfgReg[CFG_OV_INHIBIT]
      |=> thermistorPinOe)
    else $error("Charger inhibit not driven");
  a_uv_charger_chg: assert property (state == ST_UV && chgS && !lockS
      |=> chargeSwitchDrive && !dischargeSwitchDrive)
    else $error("Charge switch not enabled for charger in undervoltage");
  a_uv_unload_hold: assert property (state == ST_UV && cfgReg[CFG_UV_UNLOAD] && loadS
      |=> state != ST_NORMAL)
    else $error("Undervoltage recovered with load present");
  a_ot_unload_hold: assert property (state == ST_OT && cfgReg[CFG_TEMP_UNLOAD] && loadS
      |=> state != ST_NORMAL)
    else $error("Overtemperature recovered with load present");
  a_cur_load_hold: assert property (state == ST_CUR && loadS
      |=> state != ST_NORMAL)
    else $error("Current fault recovered with load present");
  a_scc_charger_hold: assert property (state == ST_SCC && chgS && !tshHit && !openHit
      |=> state == ST_SCC)
    else $error("Charge short left while charger present");
  a_shut_both_off: assert property (state == ST_SHUT
      |=> lowPowerMode && !chargeSwitchDrive && !dischargeSwitchDrive)
    else $error("Shutdown without both switches off");
  a_open_shut_charger: assert property (state == ST_SHUT && cause == CAUSE_OPEN && !chgS
      |=> state == ST_SHUT)
    else $error("Open-cell shutdown left without charger");
  a_uvshut_disabled: assert property (!cfgReg[CFG_UV_SHUT_EN] && !tshHit && !openHit
      |=> state != ST_SHUT || $past(state == ST_SHUT))
    else $error("Undervoltage shutdown with timer disabled");
  a_ot_recover_tick: assert property (state == ST_OT ##1 state == ST_NORMAL
      |-> $past(thermTick))
    else $error("Thermal recovery off the check tick");

  c_ov_entry: cover property ($rose(state == ST_OV));
  c_uv_recover: cover property (state == ST_UV ##1 state == ST_NORMAL);
  c_shut_recover: cover property (state == ST_SHUT ##1 state == ST_NORMAL);
  c_irq_raised: cover property ($rose(irq));

endmodule
`default_nettype wire

// ---- test/bfp_pack_model.sv ----
// Behavioural model of the power switches, charger and load around the protector
`timescale 1ns/1ps
`default_nettype none
module bfp_pack_model (
  input wire logic chargeSwitchDrive,
  input wire logic dischargeSwitchDrive,
  input wire logic thermistorPinOut,
  input wire logic thermistorPinOe,
  input wire logic chargerWanted,
  input wire logic loadWanted,
  output logic chargerPresent,
  output logic loadPresent,
  output logic thermLevel,
  output logic loadCurrent
);
  // Thermistor line has a pull-up; the open-drain driver wins only while enabled
  assign thermLevel = thermistorPinOe ? thermistorPinOut : 1'b1;
  // Charger and load are sensed at the pack terminals even with the switches open
  assign chargerPresent = chargerWanted;
  assign loadPresent = loadWanted;
  // Load current flows only through a closed discharge switch
  assign loadCurrent = loadWanted & dischargeSwitchDrive;
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the battery fault supervision state machine
`timescale 1ns/1ps
`default_nettype none
module tb import bfp_pkg::*;;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, rerr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic supplyLow, chargerWanted, loadWanted, chargerPresent, loadPresent;
  logic cellOver, cellOverClear, cellUnder, cellUnderClear, tempHot, tempHotClear;
  logic dischargeOvercurrent, dischargeShort, chargeShort, thermShort, thermShortClear;
  logic openCell, chargeSwitchDrive, dischargeSwitchDrive, thermistorPinOut, thermistorPinOe;
  logic lowPowerMode, irq, thermLevel, loadCurrent;
  int num_errors, tests_run, seed, k;

  // Filter counts shortened so every fault trips within tens of cycles
  localparam int unsigned FAST_CYC = 8;
  localparam int unsigned CHECK_CYC = 16; // Two ticks must fit well inside a poll window
  localparam int unsigned UV_TIMER_CYC = 40;
  bfp_fsm #(.OV_CYCLES(FAST_CYC), .UV_CYCLES(FAST_CYC), .OCD_CYCLES(FAST_CYC),
    .SCD_CYCLES(FAST_CYC), .SCC_CYCLES(FAST_CYC), .THERM_CYCLES(CHECK_CYC),
    .OPEN_CYCLES(CHECK_CYC), .UV_SHUT_CYCLES(UV_TIMER_CYC)) dut (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .supplyLow(supplyLow),
    .chargerPresent(chargerPresent), .loadPresent(loadPresent), .cellOver(cellOver),
    .cellOverClear(cellOverClear), .cellUnder(cellUnder), .cellUnderClear(cellUnderClear),
    .tempHot(tempHot), .tempHotClear(tempHotClear), .dischargeOvercurrent(dischargeOvercurrent),
    .dischargeShort(dischargeShort), .chargeShort(chargeShort), .thermShort(thermShort),
    .thermShortClear(thermShortClear), .openCell(openCell),
    .chargeSwitchDrive(chargeSwitchDrive), .dischargeSwitchDrive(dischargeSwitchDrive),
    .thermistorPinOut(thermistorPinOut), .thermistorPinOe(thermistorPinOe),
    .lowPowerMode(lowPowerMode), .irq(irq));

  bfp_pack_model pack (.chargeSwitchDrive(chargeSwitchDrive),
    .dischargeSwitchDrive(dischargeSwitchDrive), .thermistorPinOut(thermistorPinOut),
    .thermistorPinOe(thermistorPinOe), .chargerWanted(chargerWanted), .loadWanted(loadWanted),
    .chargerPresent(chargerPresent), .loadPresent(loadPresent), .thermLevel(thermLevel),
    .loadCurrent(loadCurrent));

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic print_verdict;
    $display("mismatches %0d of %0d comparisons", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer entered right after a rising edge; one idle edge follows it
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n == 20) begin
      num_errors++;
      print_verdict();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Polls the state code under a bounded number of reads, then lets the gates settle
  task automatic wait_state(input bfp_state_type s, input int lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      n++;
    end while (rdata[ST_W-1:0] !== s && n < lim);
    check("state", rdata[ST_W-1:0], s);
    if (rdata[ST_W-1:0] !== s) print_verdict();
    repeat (3) @(posedge mclk);
  endtask

  task automatic gates(input logic c, input logic d);
    check("chargeSwitchDrive", chargeSwitchDrive, c);
    check("dischargeSwitchDrive", dischargeSwitchDrive, d);
  endtask

  task automatic still(input bfp_state_type s);
    repeat (40) @(posedge mclk);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    check("held state", rdata[ST_W-1:0], s);
  endtask

  // Hang guard at 80000 cycles, well above the length of the whole sequence
  initial begin
    #4000000;
    num_errors++;
    print_verdict();
  end

  // Main sequence; idle comparators report every clear condition as met
  initial begin
    seed = 32'h23973a05;
    num_errors = 0;
    tests_run = 0;
    {reset, cellOverClear, cellUnderClear, tempHotClear, thermShortClear, loadWanted} = 6'h3F;
    {psel, penable, pwrite, paddr, pwdata, supplyLow, chargerWanted} = '0;
    {cellOver, cellUnder, tempHot, dischargeOvercurrent, dischargeShort} = '0;
    {chargeShort, thermShort, openCell} = '0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, ADDR_W'(a), 32'h0000_0000);
      check("reset value", rdata, 32'h0000_0000);
    end
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    apb(1'b0, 8'h10, 32'h0000_0000);
    check("unmapped pslverr", rerr, 1'b1);
    apb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    check("status read-only", rdata, 32'h0000_0000);
    apb(1'b1, REG_IRQ_MASK, 32'h0000_0001);
    $display("test registers done");
    for (int v = 1; v >= 0; v--) begin
      apb(1'b1, REG_CONFIG, {$random(seed)} & 32'hFFFF_FFE0 | 32'(v));
      apb(1'b0, REG_CONFIG, 32'h0000_0000);
      check("config", rdata, 32'(v));
      for (int i = 0; i < 3; i++) begin
        k = 1 + {$random(seed)} % 5;
        cellOver <= 1'b1;
        repeat (k) @(posedge mclk);
        cellOver <= 1'b0;
        repeat (4) @(posedge mclk);
      end
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      check("glitch state", rdata[ST_W-1:0], ST_NORMAL);
      cellOver <= 1'b1;
      cellOverClear <= 1'b0;
      wait_state(ST_OV, 30);
      gates(1'b0, 1'b1);
      check("overvolt_flag", rdata[STAT_OV], 1'b1);
      check("thermistor pin", thermLevel, !v);
      check("irq raised", irq, 1'b1);
      apb(1'b1, REG_IRQ_STATUS, 32'h0000_0001);
      @(posedge mclk);
      check("irq cleared", irq, 1'b0);
      cellOver <= 1'b0;
      cellOverClear <= 1'b1;
      wait_state(ST_NORMAL, 30);
      gates(1'b1, 1'b1);
      check("thermistorPinOe", thermistorPinOe, 1'b0);
    end
    $display("test overvoltage done");
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, REG_CONFIG, 32'(v) << CFG_UV_UNLOAD);
      cellUnder <= 1'b1;
      cellUnderClear <= 1'b0;
      wait_state(ST_UV, 30);
      gates(1'b0, 1'b0);
      check("undervolt_flag", rdata[STAT_UV], 1'b1);
      check("irq masked", irq, 1'b0);
      chargerWanted <= 1'b1;
      repeat (6) @(posedge mclk);
      gates(1'b1, 1'b0);
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      check("charger_attached_flag", rdata[STAT_CHARGER], 1'b1);
      cellUnder <= 1'b0;
      cellUnderClear <= 1'b1;
      if (v == 1) begin
        still(ST_UV);
        loadWanted <= 1'b0;
      end
      wait_state(ST_NORMAL, 30);
      gates(1'b1, 1'b1);
      loadWanted <= 1'b1;
      chargerWanted <= 1'b0;
    end
    $display("test undervoltage done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, REG_CONFIG, 32'(i >> 1) << CFG_CUR_CHARGER);
      if (i % 2) dischargeShort <= 1'b1;
      else dischargeOvercurrent <= 1'b1;
      wait_state(ST_CUR, 30);
      gates(1'b0, 1'b0);
      check("loadCurrent", loadCurrent, 1'b0);
      {dischargeShort, dischargeOvercurrent, loadWanted} <= 3'h0;
      if (i >> 1) begin
        still(ST_CUR);
        chargerWanted <= 1'b1;
      end
      wait_state(ST_NORMAL, 30);
      loadWanted <= 1'b1;
      chargerWanted <= 1'b0;
    end
    chargerWanted <= 1'b1;
    chargeShort <= 1'b1;
    wait_state(ST_SCC, 30);
    gates(1'b0, 1'b0);
    chargeShort <= 1'b0;
    still(ST_SCC);
    chargerWanted <= 1'b0;
    wait_state(ST_NORMAL, 30);
    $display("test current faults done");
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, REG_CONFIG, 32'(v) << CFG_TEMP_UNLOAD);
      tempHot <= 1'b1;
      tempHotClear <= 1'b0;
      wait_state(ST_OT, 30);
      gates(1'b0, 1'b0);
      tempHot <= 1'b0;
      tempHotClear <= 1'b1;
      if (v == 1) begin
        still(ST_OT);
        loadWanted <= 1'b0;
      end
      wait_state(ST_NORMAL, 9);
      loadWanted <= 1'b1;
    end
    thermShort <= 1'b1;
    thermShortClear <= 1'b0;
    wait_state(ST_SHUT, 30);
    gates(1'b0, 1'b0);
    check("lowPowerMode", lowPowerMode, 1'b1);
    thermShort <= 1'b0;
    thermShortClear <= 1'b1;
    still(ST_SHUT);
    chargerWanted <= 1'b1;
    wait_state(ST_NORMAL, 9);
    check("lowPowerMode", lowPowerMode, 1'b0);
    chargerWanted <= 1'b0;
    openCell <= 1'b1;
    wait_state(ST_SHUT, 30);
    gates(1'b0, 1'b0);
    openCell <= 1'b0;
    chargerWanted <= 1'b1;
    wait_state(ST_NORMAL, 30);
    chargerWanted <= 1'b0;
    $display("test thermistor and open cell done");
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, REG_CONFIG, 32'(v) << CFG_UV_SHUT_EN);
      cellUnder <= 1'b1;
      cellUnderClear <= 1'b0;
      wait_state(ST_UV, 30);
      repeat (60) @(posedge mclk);
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      check("uv timer state", rdata[ST_W-1:0], v ? ST_SHUT : ST_UV);
      {cellUnder, cellUnderClear, chargerWanted} <= 3'h3;
      wait_state(ST_NORMAL, 30);
      chargerWanted <= 1'b0;
    end
    supplyLow <= 1'b1;
    repeat (6) @(posedge mclk);
    gates(1'b0, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    check("supply_lockout_flag", rdata[STAT_LOCKOUT], 1'b1);
    supplyLow <= 1'b0;
    repeat (6) @(posedge mclk);
    gates(1'b1, 1'b1);
    $display("test timer and lockout done");
    print_verdict();
  end
endmodule
`default_nettype wire
